// File: hdl/rhc_config_regs.sv
// Purpose: Serial host port and first three configuration words.
// Assumes: Host pins are synchronous to clk and sampled at their edges.
// Notes: Frame is 16-bit command, 16-bit data, 32 cycles of echo.
// Function
// - Offset correction bit eight resets set
// - Input one decode: bit three, bit seven
// - Input zero decode: bit zero, bit four
// - Swing bits nine and eight, reset 400mV
// - Output one de-emphasis and boost seven:five
// - Output zero de-emphasis and boost four:two
// - Loss method six:five, threshold eight:seven
// - Tri-state serial output when deselected
// - MSB first, rise sample, fall launch
// - Command reset bit low restores defaults
`timescale 1ns/1ns
module rhc_config_regs
   import rhc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial host port
   input wire logic host_sclk,
   input wire logic host_cs_n,
   input wire logic host_sdi,
   output logic host_sdo,
   output logic host_sdo_oe,
   // Detector inputs
   input wire logic edge_signal_seen,
   input wire logic strength_signal_seen,
   // Decoded configuration
   output rhc_input_cfg_t input_zero_cfg,
   output rhc_input_cfg_t input_one_cfg,
   output rhc_output_cfg_t output_zero_cfg,
   output rhc_output_cfg_t output_one_cfg,
   output logic [1:0] los_threshold,
   output logic signal_loss_flag,
   output logic output_mute,
   output logic power_down,
   output logic xtal_buffer_disable,
   output logic data_invert
);
   logic [WORD_W-1:0] input_equalizer_control;
   logic [WORD_W-1:0] output_driver_control;
   logic [WORD_W-1:0] top_level_control;
   logic sclk_d;
   logic [CNT_W-1:0] bit_cnt;
   logic [WORD_W-1:0] shift_in;
   logic [WORD_W-1:0] command;
   logic [WORD_W-1:0] shift_out;
   logic [FRAME_BITS-1:0] echo;
   logic read_active;
   logic sclk_rise;
   logic sclk_fall;
   logic [WORD_W-1:0] next_shift_in;
   logic [WORD_W-1:0] read_word;
   logic cmd_for_me;
   logic write_go;
   logic reset_go;
   logic [1:0] method;

   assign sclk_rise = host_sclk && !sclk_d && !host_cs_n;
   assign sclk_fall = !host_sclk && sclk_d && !host_cs_n;
   assign next_shift_in = {shift_in[WORD_W-2:0], host_sdi};
   assign cmd_for_me = command[CMD_CHAIN_LSB +: CHAIN_W] == '0;

   // Command is taken on the 16th rising edge, data on the 32nd.
   assign reset_go = sclk_rise && bit_cnt == CNT_W'(WORD_W - 1) &&
      !next_shift_in[CMD_RST_N];
   assign write_go = sclk_rise && bit_cnt == CNT_W'(FRAME_BITS - 1) &&
      !command[CMD_RW] && command[CMD_RST_N] && cmd_for_me;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sclk_d <= 1'b0;
      else
         sclk_d <= host_sclk;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt <= '0;
         shift_in <= '0;
         command <= '0;
         echo <= '1;
      end
      else if (host_cs_n)
         bit_cnt <= '0;
      else if (sclk_rise)
      begin
         shift_in <= next_shift_in;
         echo <= {echo[FRAME_BITS-2:0], host_sdi};
         if (bit_cnt == CNT_W'(WORD_W - 1))
            command <= next_shift_in;
         if (bit_cnt != CNT_W'(2 * FRAME_BITS - 1))
            bit_cnt <= bit_cnt + CNT_W'(1);
      end
   end

   always_comb
   begin
      case (command[CMD_ADDR_W-1:0])
         ADDR_EQ[CMD_ADDR_W-1:0]: read_word = input_equalizer_control;
         ADDR_DRV[CMD_ADDR_W-1:0]: read_word = output_driver_control;
         ADDR_TOP[CMD_ADDR_W-1:0]: read_word = top_level_control;
         default: read_word = '0;
      endcase
   end

   // Output changes on falling edges; echo carries the chained command.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         shift_out <= '1;
         read_active <= 1'b0;
         host_sdo <= 1'b1;
      end
      else if (host_cs_n)
         read_active <= 1'b0;
      else if (sclk_fall)
      begin
         if (bit_cnt == CNT_W'(FRAME_BITS) && command[CMD_RW] &&
            command[CMD_RST_N] && cmd_for_me)
         begin
            read_active <= 1'b1;
            host_sdo <= read_word[WORD_W-1];
            shift_out <= {read_word[WORD_W-2:0], 1'b1};
         end
         else if (read_active)
         begin
            host_sdo <= shift_out[WORD_W-1];
            shift_out <= {shift_out[WORD_W-2:0], 1'b1};
         end
         else if (bit_cnt == CNT_W'(WORD_W) && !cmd_for_me)
            host_sdo <= 1'b1;
         else
            host_sdo <= echo[FRAME_BITS-1];
      end
   end

   assign host_sdo_oe = !(top_level_control[TOP_TRI] && host_cs_n);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         input_equalizer_control <= EQ_RESET;
      else if (reset_go)
         input_equalizer_control <= EQ_RESET;
      else if (write_go && command[CMD_ADDR_W-1:0] == ADDR_EQ[CMD_ADDR_W-1:0])
         input_equalizer_control <= next_shift_in & EQ_MASK;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         output_driver_control <= DRV_RESET;
      else if (reset_go)
         output_driver_control <= DRV_RESET;
      else if (write_go && command[CMD_ADDR_W-1:0] == ADDR_DRV[CMD_ADDR_W-1:0])
         output_driver_control <= next_shift_in & DRV_MASK;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         top_level_control <= TOP_RESET;
      else if (reset_go)
         top_level_control <= TOP_RESET;
      else if (write_go && command[CMD_ADDR_W-1:0] == ADDR_TOP[CMD_ADDR_W-1:0])
         top_level_control <= next_shift_in & TOP_MASK;
   end

   rhc_eq_decode u_eq0 (
      .enable(input_equalizer_control[EQ_EN0]),
      .gain(input_equalizer_control[EQ_GAIN0]),
      .level(input_zero_cfg.eq_level)
   );
   rhc_eq_decode u_eq1 (
      .enable(input_equalizer_control[EQ_EN1]),
      .gain(input_equalizer_control[EQ_GAIN1]),
      .level(input_one_cfg.eq_level)
   );
   assign input_zero_cfg.offset_correct = input_equalizer_control[EQ_OFFSET];
   assign input_one_cfg.offset_correct = input_equalizer_control[EQ_OFFSET];
   assign input_zero_cfg.atten_enable = input_equalizer_control[EQ_ATTEN];
   assign input_one_cfg.atten_enable = input_equalizer_control[EQ_ATTEN];

   assign output_zero_cfg.amp_400mv = output_driver_control[DRV_AMP0];
   assign output_one_cfg.amp_400mv = output_driver_control[DRV_AMP1];
   assign output_one_cfg.de_enable = output_driver_control[DRV_DE1];
   assign output_one_cfg.boost = output_driver_control[DRV_BOOST1 +: 3];
   assign output_zero_cfg.de_enable = output_driver_control[DRV_DE0];
   assign output_zero_cfg.boost = output_driver_control[DRV_BOOST0 +: 3];

   assign method = top_level_control[TOP_METHOD +: 2];
   assign los_threshold = top_level_control[TOP_THRESH +: 2];

   // Reserved method code 3 is treated as dual, the safest reading.
   always_comb
   begin
      case (method)
         LOS_EDGE: signal_loss_flag = !edge_signal_seen;
         LOS_STRENGTH: signal_loss_flag = !strength_signal_seen;
         default: signal_loss_flag = !(edge_signal_seen &&
            strength_signal_seen);
      endcase
   end

   assign output_mute = top_level_control[TOP_MUTE] &&
      signal_loss_flag;
   assign power_down = top_level_control[TOP_PD];
   assign xtal_buffer_disable = top_level_control[TOP_XTAL];
   assign data_invert = top_level_control[TOP_POL];

   a_offset_reset: assert property (
      @(posedge clk) disable iff (rst)
      reset_go |=> input_equalizer_control[EQ_OFFSET])
      else $error("offset correction not set after reset command");
   a_eq1_decode: assert property (
      @(posedge clk) disable iff (rst)
      !input_equalizer_control[EQ_EN1] |->
      input_one_cfg.eq_level == rhc_eq_low)
      else $error("input one level wrong while disabled");
   a_eq0_decode: assert property (
      @(posedge clk) disable iff (rst)
      input_equalizer_control[EQ_EN0] && input_equalizer_control[EQ_GAIN0]
      |-> input_zero_cfg.eq_level == rhc_eq_high)
      else $error("input zero level not high");
   a_swing_reset: assert property (
      @(posedge clk) disable iff (rst)
      reset_go |=> output_one_cfg.amp_400mv && output_zero_cfg.amp_400mv)
      else $error("swing not 400mV after reset command");
   a_boost_reset: assert property (
      @(posedge clk) disable iff (rst)
      reset_go |=> output_one_cfg.boost == 3'h2 &&
      output_zero_cfg.boost == 3'h2 && !output_one_cfg.de_enable &&
      !output_zero_cfg.de_enable)
      else $error("boost or de-emphasis reset wrong");
   a_los_dual: assert property (
      @(posedge clk) disable iff (rst)
      method == LOS_DUAL && !strength_signal_seen |-> signal_loss_flag)
      else $error("dual detection cleared loss");
   a_sdo_tristate: assert property (
      @(posedge clk) disable iff (rst)
      top_level_control[TOP_TRI] && host_cs_n |-> !host_sdo_oe)
      else $error("serial output driven while deselected");
   a_sdo_selected: assert property (
      @(posedge clk) disable iff (rst)
      !host_cs_n |-> host_sdo_oe)
      else $error("serial output released while selected");
   a_mute_gate: assert property (
      @(posedge clk) disable iff (rst)
      output_mute |-> top_level_control[TOP_MUTE] && signal_loss_flag)
      else $error("mute without enable and loss");
   a_mute_nosignal: assert property (
      @(posedge clk) disable iff (rst)
      top_level_control[TOP_MUTE] && !edge_signal_seen &&
      !strength_signal_seen |-> output_mute)
      else $error("no mute with enable set and no signal");
   a_write_lands: assert property (
      @(posedge clk) disable iff (rst)
      write_go && command[CMD_ADDR_W-1:0] == ADDR_TOP[CMD_ADDR_W-1:0]
      |=> data_invert == $past(next_shift_in[TOP_POL]))
      else $error("write to top word not applied");
endmodule

// File: hdl/rhc_eq_decode.sv
// Purpose: Decodes one input's enable and gain bits into a level.
// Assumes: Purely combinational.
// Notes: Gain only matters when the equalizer is enabled.
`timescale 1ns/1ns
module rhc_eq_decode
   import rhc_pkg::*;
(
   // Register bits
   input wire logic enable,
   input wire logic gain,
   // Decoded level
   output rhc_eq_t level
);
   always_comb
   begin
      if (!enable)
         level = rhc_eq_low;
      else if (gain)
         level = rhc_eq_high;
      else
         level = rhc_eq_med;
   end
endmodule

// File: hdl/rhc_pkg.sv
// Purpose: Shared constants and types for the reclocker configuration bank.
// Assumes: 16-bit words, 32-cycle frame of command plus data, MSB first.
// Notes: Register indices are the printed word addresses.
package rhc_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 12;
   localparam int CHAIN_W = 7;
   localparam logic [ADDR_W-1:0] ADDR_EQ = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_DRV = 12'h001;
   localparam logic [ADDR_W-1:0] ADDR_TOP = 12'h002;
   // Command word layout: rw, two reserved, reset_n, chain, address.
   localparam int CMD_RW = 15;
   localparam int CMD_RST_N = 12;
   localparam int CMD_CHAIN_LSB = 5;
   localparam int CMD_ADDR_W = 5;
   localparam int FRAME_BITS = 32;
   localparam int CNT_W = 6;
   // Field positions.
   localparam int EQ_EN0 = 0;
   localparam int EQ_EN1 = 3;
   localparam int EQ_GAIN0 = 4;
   localparam int EQ_GAIN1 = 7;
   localparam int EQ_OFFSET = 8;
   localparam int EQ_ATTEN = 9;
   localparam int DRV_DE0 = 0;
   localparam int DRV_DE1 = 1;
   localparam int DRV_BOOST0 = 2;
   localparam int DRV_BOOST1 = 5;
   localparam int DRV_AMP0 = 8;
   localparam int DRV_AMP1 = 9;
   localparam int TOP_POL = 0;
   localparam int TOP_XTAL = 1;
   localparam int TOP_TRI = 2;
   localparam int TOP_PD = 3;
   localparam int TOP_MUTE = 4;
   localparam int TOP_METHOD = 5;
   localparam int TOP_THRESH = 7;
   // Writable masks and reset values.
   localparam logic [WORD_W-1:0] EQ_MASK = 16'h0399;
   localparam logic [WORD_W-1:0] DRV_MASK = 16'h03FF;
   localparam logic [WORD_W-1:0] TOP_MASK = 16'h01FF;
   localparam logic [WORD_W-1:0] EQ_RESET = 16'h0100;
   localparam logic [WORD_W-1:0] DRV_RESET = 16'h0348;
   localparam logic [WORD_W-1:0] TOP_RESET = 16'h0000;
   localparam logic [1:0] LOS_EDGE = 2'h0;
   localparam logic [1:0] LOS_STRENGTH = 2'h1;
   localparam logic [1:0] LOS_DUAL = 2'h2;
   typedef enum logic [1:0] {rhc_eq_low, rhc_eq_med, rhc_eq_high} rhc_eq_t;
   typedef struct packed {
      rhc_eq_t eq_level;
      logic offset_correct;
      logic atten_enable;
   } rhc_input_cfg_t;
   typedef struct packed {
      logic amp_400mv;
      logic de_enable;
      logic [2:0] boost;
   } rhc_output_cfg_t;
endpackage

// File: verif/rhc_config_regs_tb.sv
// Purpose: Self-checking bench for the configuration bank.
// Assumes: The host model paces every frame.
// Notes: Detector levels are driven by the bench.
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
$display("ERROR %s exp %h got %h", n, e, a); end end
module rhc_config_regs_tb import rhc_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic edge_seen = 1'b0;
   logic strength_seen = 1'b0;
   wire logic host_sclk, host_cs_n, host_sdi, host_sdo, host_sdo_oe;
   wire sdo_w;
   rhc_input_cfg_t in0, in1;
   rhc_output_cfg_t out0, out1;
   logic [1:0] thr;
   logic loss, mute, pd, xtal, inv;
   int checks = 0;
   int n_fail = 0;
   always #50 clk = ~clk;
   // A released SDO floats so a wrong enable spoils the readback.
   assign sdo_w = host_sdo_oe ? host_sdo : 1'bz;
   rhc_config_regs i_rhc_config_regs (.clk(clk), .rst(rst),
      .host_sclk(host_sclk), .host_cs_n(host_cs_n), .host_sdi(host_sdi),
      .host_sdo(host_sdo), .host_sdo_oe(host_sdo_oe),
      .edge_signal_seen(edge_seen), .strength_signal_seen(strength_seen),
      .input_zero_cfg(in0), .input_one_cfg(in1), .output_zero_cfg(out0),
      .output_one_cfg(out1), .los_threshold(thr), .signal_loss_flag(loss),
      .output_mute(mute), .power_down(pd), .xtal_buffer_disable(xtal),
      .data_invert(inv));
   rhc_host_model i_rhc_host_model (.clk(clk), .host_sclk(host_sclk),
      .host_cs_n(host_cs_n), .host_sdi(host_sdi), .host_sdo(sdo_w));
   task automatic wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] x;
      logic [15:0] c;
      c = {4'h1, 7'h00, a};
      i_rhc_host_model.xfer(c, d, x);
      // A write frame returns its own command word 32 SCLK cycles later.
      `CHK("echo", c, x)
   endtask
   task automatic rchk(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] x;
      i_rhc_host_model.xfer({4'h9, 7'h00, a}, 16'hFFFF, x);
      `CHK("readback", e, x)
   endtask
   task automatic t_reset;
      rchk(5'h00, 16'h0100);
      rchk(5'h01, 16'h0348);
      rchk(5'h02, 16'h0000);
      `CHK("offset", 1'b1, in0.offset_correct)
      `CHK("eq0", rhc_eq_low, in0.eq_level)
      `CHK("amp0", 1'b1, out0.amp_400mv)
      `CHK("boost1", 3'h2, out1.boost)
      `CHK("de0", 1'b0, out0.de_enable)
      $display("t_reset done");
   endtask
   task automatic t_eq;
      logic [1:0] k, j;
      logic [1:0] w;
      rhc_eq_t l0, l1;
      for (int i = 0; i < 4; i++)
      begin
         k = 2'(i);
         j = ~k;
         l0 = !k[0] ? rhc_eq_low : (k[1] ? rhc_eq_high : rhc_eq_med);
         l1 = !j[0] ? rhc_eq_low : (j[1] ? rhc_eq_high : rhc_eq_med);
         w = {1'b1, k[1]};
         wr(5'h00, {6'h00, k[1], 1'b1, j[1], 2'h0, k[1], j[0], 2'h0, k[0]});
         `CHK("eq0", l0, in0.eq_level)
         `CHK("eq1", l1, in1.eq_level)
         `CHK("cfg0", w, {in0.offset_correct, in0.atten_enable})
         `CHK("cfg1", w, {in1.offset_correct, in1.atten_enable})
      end
      $display("t_eq done");
   endtask
   task automatic t_drv;
      logic [15:0] v;
      for (int i = 0; i < 2; i++)
      begin
         v = i ? 16'h01FE : 16'h02B9;
         wr(5'h01, v);
         `CHK("out1", {v[9], v[1], v[7:5]}, out1)
         `CHK("out0", {v[8], v[0], v[4:2]}, out0)
         rchk(5'h01, v);
      end
      $display("t_drv done");
   endtask
   task automatic t_top;
      logic x;
      // Method code 3 is reserved and is expected to act as dual.
      for (int m = 0; m < 4; m++)
      begin
         wr(5'h02, 16'h001B | (16'(m) << 5) | (16'(3 - m) << 7));
         `CHK("thr", 2'(3 - m), thr)
         `CHK("misc", 3'h7, {pd, xtal, inv})
         for (int d = 0; d < 4; d++)
         begin
            @(negedge clk);
            edge_seen = d[0];
            strength_seen = d[1];
            x = m == 0 ? !d[0] : (m == 1 ? !d[1] : !(d[0] && d[1]));
            @(negedge clk);
            `CHK("loss", x, loss)
            `CHK("mute", x, mute)
         end
      end
      edge_seen = 1'b0;
      wr(5'h02, 16'h0000);
      `CHK("loss", 1'b1, loss)
      `CHK("mute_off", 1'b0, mute)
      `CHK("misc", 3'h0, {pd, xtal, inv})
      $display("t_top done");
   endtask
   task automatic t_tri;
      wr(5'h02, 16'h0004);
      @(negedge clk);
      `CHK("oe_idle", 1'b0, host_sdo_oe)
      rchk(5'h02, 16'h0004);
      wr(5'h02, 16'h0000);
      `CHK("oe_on", 1'b1, host_sdo_oe)
      $display("t_tri done");
   endtask
   task automatic t_rstcmd;
      logic [15:0] x;
      wr(5'h01, 16'h0000);
      wr(5'h02, 16'h01FF);
      i_rhc_host_model.xfer(16'h0000, 16'h0000, x);
      `CHK("echo_rst", 16'h0000, x)
      rchk(5'h00, 16'h0100);
      rchk(5'h01, 16'h0348);
      rchk(5'h02, 16'h0000);
      $display("t_rstcmd done");
   endtask
   initial
   begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_eq;
      t_drv;
      t_top;
      t_tri;
      t_rstcmd;
      wrap_up;
   end
   // About 25 frames of 261 cycles each fit well inside this span.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up;
   end
endmodule

// File: verif/rhc_host_model.sv
// Purpose: Host master model for the serial configuration port.
// Assumes: SCLK runs at four clk cycles per bit and idles low.
// Notes: SDI shows the inverse of its last bit once CS is released.
`timescale 1ns/1ns
module rhc_host_model
(
   // Clock
   input wire logic clk,
   // Host pins
   output logic host_sclk,
   output logic host_cs_n,
   output logic host_sdi,
   input wire logic host_sdo
);
   initial
   begin
      host_sclk = 1'b0;
      host_cs_n = 1'b1;
      host_sdi = 1'b1;
   end
   // One 64-bit frame; rd collects the 16 SDO bits after rise 32.
   task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd,
                       output logic [15:0] rd);
      logic [63:0] f;
      f = {cmd, wd, 32'hFFFF_FFFF};
      @(negedge clk);
      host_cs_n = 1'b0;
      for (int i = 63; i >= 0; i--)
      begin
         host_sdi = f[i];
         repeat (2) @(negedge clk);
         if (i < 32 && i >= 16)
            rd[i-16] = host_sdo;
         host_sclk = 1'b1;
         repeat (2) @(negedge clk);
         host_sclk = 1'b0;
      end
      repeat (2) @(negedge clk);
      host_cs_n = 1'b1;
      host_sdi = ~host_sdi;
      repeat (2) @(negedge clk);
   endtask
endmodule
